// *** rtl/vigo_config.sv ***
// configuration register bank of the three-channel video digitizer front end
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module vigo_config
  import vigo_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              black_level_compensation,
  input  wire logic              coast,
  input  wire logic              clamp_time,
  input  wire logic              hsync_in,
  input  wire logic              green_sync_input,
  output logic                   second_input_set,
  output logic                   clamp_pos_red,
  output logic                   clamp_pos_green,
  output logic                   clamp_pos_blue,
  output logic                   clamp_neg_tied,
  output logic                   analog_clamp,
  output vigo_pkg::vigo_clamp_type clamp_level_red,
  output vigo_pkg::vigo_clamp_type clamp_level_green,
  output vigo_pkg::vigo_clamp_type clamp_level_blue,
  output logic                   shift_red,
  output logic                   shift_green,
  output logic                   shift_blue,
  output logic      [7:0]        target_red,
  output logic      [7:0]        target_green,
  output logic      [7:0]        target_blue,
  output logic                   compensation_active,
  output logic      [7:0]        gain_red,
  output logic      [7:0]        gain_green,
  output logic      [7:0]        gain_blue,
  output logic signed [8:0]      digital_offset_red,
  output logic signed [8:0]      digital_offset_green,
  output logic signed [8:0]      digital_offset_blue,
  output logic      [9:0]        offset_dac_red,
  output logic      [9:0]        offset_dac_green,
  output logic      [9:0]        offset_dac_blue,
  output logic                   offset_range_quarter,
  output logic                   sync_out,
  output logic                   composite_sync
);
  import vigo_pkg::*;

  typedef struct packed {
    logic [7:0] in_cfg;
    logic [7:0] gain_r;
    logic [7:0] gain_g;
    logic [7:0] gain_b;
    logic [7:0] ofs_r;
    logic [7:0] ofs_g;
    logic [7:0] ofs_b;
    logic [7:0] dac_cfg;
    logic [7:0] rdata;
    logic       clamp_p;
    logic       clamp_n;
    logic       aclamp;
    logic       yuv;
    logic       comp_on;
  } vigo_state_type;

  vigo_state_type st_ff;
  vigo_state_type nxt_st;

  // read mux for the register map; unmapped addresses read zero
  function automatic logic [7:0] vigo_read(input vigo_state_type s,
                                           input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_INPUT_CONFIG: v = s.in_cfg;
      ADDR_RED_GAIN:     v = s.gain_r;
      ADDR_GREEN_GAIN:   v = s.gain_g;
      ADDR_BLUE_GAIN:    v = s.gain_b;
      ADDR_RED_OFFSET:   v = s.ofs_r;
      ADDR_GREEN_OFFSET: v = s.ofs_g;
      ADDR_BLUE_OFFSET:  v = s.ofs_b;
      ADDR_OFFSET_DAC:   v = s.dac_cfg;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction : vigo_read

  logic clamp_allowed;
  logic coupling_dc;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    if (reg_rd)
      nxt_st.rdata = vigo_read(st_ff, reg_addr);
    if (reg_wr)
    begin
      case (reg_addr)
        // reserved bits are kept zero in hardware too
        ADDR_INPUT_CONFIG:
          nxt_st.in_cfg = reg_wdata & MASK_INPUT_CONFIG;
        ADDR_RED_GAIN:     nxt_st.gain_r = reg_wdata;
        ADDR_GREEN_GAIN:   nxt_st.gain_g = reg_wdata;
        ADDR_BLUE_GAIN:    nxt_st.gain_b = reg_wdata;
        ADDR_RED_OFFSET:   nxt_st.ofs_r  = reg_wdata;
        ADDR_GREEN_OFFSET: nxt_st.ofs_g  = reg_wdata;
        ADDR_BLUE_OFFSET:  nxt_st.ofs_b  = reg_wdata;
        ADDR_OFFSET_DAC:
          nxt_st.dac_cfg = reg_wdata & MASK_OFFSET_DAC;
        default:           nxt_st.rdata = nxt_st.rdata;
      endcase
    end

    coupling_dc   = st_ff.in_cfg[BIT_DC_COUPLING];
    // coast suspends clamping unless coast-clamp is enabled
    clamp_allowed = !coast || st_ff.in_cfg[BIT_COAST_CLAMP];
    if (coupling_dc)
    begin
      nxt_st.clamp_p = 1'b0;
      nxt_st.clamp_n = 1'b0;
      nxt_st.aclamp  = 1'b0;
    end
    else
    begin
      nxt_st.clamp_p = clamp_time && clamp_allowed;
      nxt_st.clamp_n = 1'b1;
      nxt_st.aclamp  = clamp_time && clamp_allowed;
    end
    nxt_st.yuv     = st_ff.in_cfg[BIT_COLOUR_SPACE];
    nxt_st.comp_on = black_level_compensation && clamp_allowed;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_ff         <= '0;
      st_ff.in_cfg  <= RST_INPUT_CONFIG;
      st_ff.gain_r  <= RST_GAIN;
      st_ff.gain_g  <= RST_GAIN;
      st_ff.gain_b  <= RST_GAIN;
      st_ff.ofs_r   <= RST_OFFSET;
      st_ff.ofs_g   <= RST_OFFSET;
      st_ff.ofs_b   <= RST_OFFSET;
      st_ff.dac_cfg <= RST_OFFSET_DAC;
    end
    else
      st_ff <= nxt_st;
  end

  assign reg_rdata        = st_ff.rdata;
  assign second_input_set = st_ff.in_cfg[BIT_CHANNEL_SELECT];
  assign clamp_pos_red    = st_ff.clamp_p;
  assign clamp_pos_green  = st_ff.clamp_p;
  assign clamp_pos_blue   = st_ff.clamp_p;
  assign clamp_neg_tied   = st_ff.clamp_n;
  assign analog_clamp     = st_ff.aclamp;

  // colour space: RGB treats all alike, YUV lifts R/B clamp and target
  assign clamp_level_red   = st_ff.yuv ? vigo_clamp_600mv_type_e
                                       : vigo_clamp_300mv_type_e;
  assign clamp_level_green = vigo_clamp_300mv_type_e;
  assign clamp_level_blue  = st_ff.yuv ? vigo_clamp_600mv_type_e
                                       : vigo_clamp_300mv_type_e;
  assign shift_red    = !st_ff.yuv;
  assign shift_green  = 1'b1;
  assign shift_blue   = !st_ff.yuv;
  assign target_red   = st_ff.yuv ? TARGET_CHROMA : TARGET_BASE;
  assign target_green = TARGET_BASE;
  assign target_blue  = st_ff.yuv ? TARGET_CHROMA : TARGET_BASE;
  assign compensation_active = st_ff.comp_on;

  // analog gain = 0.5 + code/170, code passed straight to the gain stage
  assign gain_red   = st_ff.gain_r;
  assign gain_green = st_ff.gain_g;
  assign gain_blue  = st_ff.gain_b;

  assign offset_range_quarter = st_ff.dac_cfg[BIT_OFFSET_RANGE];

  vigo_chan_map u_map_red (
    .clk            (clk),
    .nrst           (nrst),
    .offset_code    (st_ff.ofs_r),
    .dac_lsbs       (st_ff.dac_cfg[POS_RED_DAC_LSB +: 2]),
    .black_level_on (black_level_compensation),
    .digital_offset (digital_offset_red),
    .offset_dac     (offset_dac_red)
  );

  vigo_chan_map u_map_green (
    .clk            (clk),
    .nrst           (nrst),
    .offset_code    (st_ff.ofs_g),
    .dac_lsbs       (st_ff.dac_cfg[POS_GREEN_DAC_LSB +: 2]),
    .black_level_on (black_level_compensation),
    .digital_offset (digital_offset_green),
    .offset_dac     (offset_dac_green)
  );

  vigo_chan_map u_map_blue (
    .clk            (clk),
    .nrst           (nrst),
    .offset_code    (st_ff.ofs_b),
    .dac_lsbs       (st_ff.dac_cfg[POS_BLUE_DAC_LSB +: 2]),
    .black_level_on (black_level_compensation),
    .digital_offset (digital_offset_blue),
    .offset_dac     (offset_dac_blue)
  );

  vigo_sync_mux u_sync (
    .clk              (clk),
    .nrst             (nrst),
    .sync_type        (st_ff.in_cfg[BIT_SYNC_TYPE]),
    .composite_src    (st_ff.in_cfg[BIT_COMPOSITE_SRC]),
    .hsync_in         (hsync_in),
    .green_sync_input (green_sync_input),
    .sync_out         (sync_out),
    .composite_sync   (composite_sync)
  );
endmodule : vigo_config

// *** include/vigo_pkg.sv ***
// register map, field positions and types of the video config block
package vigo_pkg;
  localparam logic [7:0] ADDR_INPUT_CONFIG  = 8'h05;
  localparam logic [7:0] ADDR_RED_GAIN      = 8'h06;
  localparam logic [7:0] ADDR_GREEN_GAIN    = 8'h07;
  localparam logic [7:0] ADDR_BLUE_GAIN     = 8'h08;
  localparam logic [7:0] ADDR_RED_OFFSET    = 8'h09;
  localparam logic [7:0] ADDR_GREEN_OFFSET  = 8'h0A;
  localparam logic [7:0] ADDR_BLUE_OFFSET   = 8'h0B;
  localparam logic [7:0] ADDR_OFFSET_DAC    = 8'h0C;

  localparam logic [7:0] RST_INPUT_CONFIG   = 8'h00;
  localparam logic [7:0] RST_GAIN           = 8'h55;
  localparam logic [7:0] RST_OFFSET         = 8'h80;
  localparam logic [7:0] RST_OFFSET_DAC     = 8'h00;

  localparam int BIT_CHANNEL_SELECT  = 0;
  localparam int BIT_DC_COUPLING     = 1;
  localparam int BIT_COLOUR_SPACE    = 2;
  localparam int BIT_SYNC_TYPE       = 3;
  localparam int BIT_COMPOSITE_SRC   = 4;
  localparam int BIT_COAST_CLAMP     = 5;
  localparam int BIT_OFFSET_RANGE    = 0;
  localparam int POS_RED_DAC_LSB     = 2;
  localparam int POS_GREEN_DAC_LSB   = 4;
  localparam int POS_BLUE_DAC_LSB    = 6;

  localparam logic [7:0] MASK_INPUT_CONFIG = 8'h3F;
  localparam logic [7:0] MASK_OFFSET_DAC   = 8'hFD;

  // black level targets
  localparam logic [7:0] TARGET_BASE   = 8'h00;
  localparam logic [7:0] TARGET_CHROMA = 8'h80;
  // digital offset zero point
  localparam logic [7:0] OFFSET_ZERO   = 8'h80;

  // clamp level selection: low is 300 mV, high is 600 mV
  typedef enum logic { vigo_clamp_300mv_type_e, vigo_clamp_600mv_type_e }
    vigo_clamp_type;
endpackage : vigo_pkg

// *** rtl/vigo_chan_map.sv ***
// per-channel mapping of offset code onto digital offset or offset DAC
`timescale 1ns/10ps
module vigo_chan_map
  import vigo_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] offset_code,
  input  wire logic [1:0] dac_lsbs,
  input  wire logic       black_level_on,
  output logic signed [8:0] digital_offset,
  output logic      [9:0]   offset_dac
);
  typedef struct packed {
    logic signed [8:0] dig;
    logic        [9:0] dac;
  } vigo_map_state_type;

  vigo_map_state_type st_ff;
  vigo_map_state_type nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (black_level_on)
    begin
      // one output step per code step, code 0x80 is zero
      nxt_st.dig = $signed({1'b0, offset_code}) -
                   $signed({1'b0, OFFSET_ZERO});
    end
    else
    begin
      nxt_st.dig = '0;
      nxt_st.dac = {offset_code, dac_lsbs};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_ff.dig <= '0;
      st_ff.dac <= {RST_OFFSET, 2'b00};
    end
    else
      st_ff <= nxt_st;
  end

  assign digital_offset = st_ff.dig;
  assign offset_dac     = st_ff.dac;
endmodule : vigo_chan_map

// *** rtl/vigo_sync_mux.sv ***
// sync source selection and composite sync flag for the video front end
`timescale 1ns/10ps
module vigo_sync_mux
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sync_type,
  input  wire logic composite_src,
  input  wire logic hsync_in,
  input  wire logic green_sync_input,
  output logic      sync_out,
  output logic      composite_sync
);
  typedef struct packed {
    logic sync;
    logic comp;
  } vigo_sync_state_type;

  vigo_sync_state_type st_ff;
  vigo_sync_state_type nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.comp = sync_type;
    if (!sync_type)
      nxt_st.sync = hsync_in;
    else if (composite_src)
      nxt_st.sync = hsync_in;
    else
      nxt_st.sync = green_sync_input;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign sync_out       = st_ff.sync;
  assign composite_sync = st_ff.comp;
endmodule : vigo_sync_mux

// *** sim/vigo_config_sva.sv ***
// assertion checker for the video configuration register bank
`timescale 1ns/10ps
module vigo_config_sva
  import vigo_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    black_level_compensation,
  input wire logic                    coast,
  input wire logic                    clamp_time,
  input wire logic                    hsync_in,
  input wire logic                    clamp_pos_red,
  input wire logic                    clamp_pos_green,
  input wire logic                    clamp_pos_blue,
  input wire logic                    clamp_neg_tied,
  input wire logic                    analog_clamp,
  input wire vigo_pkg::vigo_clamp_type clamp_level_red,
  input wire vigo_pkg::vigo_clamp_type clamp_level_green,
  input wire logic                    shift_red,
  input wire logic                    shift_green,
  input wire logic                    shift_blue,
  input wire logic [7:0]              target_red,
  input wire logic [7:0]              target_green,
  input wire logic                    compensation_active,
  input wire logic                    sync_out,
  input wire logic                    composite_sync
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // derived outputs are only meaningful one edge after reset has gone
  sequence up_s;
    $past(nrst);
  endsequence
  // sampled reset keeps a request made on a reset edge from counting
  sequence comp_req_s;
    nrst && black_level_compensation && !coast;
  endsequence
  rdata_slot_a: assert property (
    up_s ##0 !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  dc_off_a: assert property (
    up_s ##0 !clamp_neg_tied |-> !analog_clamp)
    else $error("clamp active in dc mode");
  clamp_win_a: assert property (
    up_s ##0 !$past(clamp_time) |-> !analog_clamp)
    else $error("clamp outside clamp time");
  clamp_same_a: assert property (
    clamp_pos_red |-> analog_clamp && clamp_pos_green && clamp_pos_blue)
    else $error("clamp pulses differ");
  rgb_mode_a: assert property (
    up_s ##0 shift_red |-> target_red == 8'h00 && shift_blue &&
    clamp_level_red == vigo_clamp_300mv_type_e)
    else $error("rgb mode mismatch");
  yuv_mode_a: assert property (
    up_s ##0 !shift_red |-> target_red == 8'h80 &&
    clamp_level_red == vigo_clamp_600mv_type_e)
    else $error("yuv mismatch");
  green_chan_a: assert property (
    up_s |-> shift_green && target_green == 8'h00 &&
    clamp_level_green == vigo_clamp_300mv_type_e)
    else $error("green wrong");
  comp_on_a: assert property (comp_req_s |=> compensation_active)
    else $error("compensation not active");
  comp_off_a: assert property (
    !black_level_compensation |=> !compensation_active)
    else $error("compensation active while off");
  sync_sep_a: assert property (
    up_s ##0 !composite_sync |-> sync_out == $past(hsync_in))
    else $error("separate sync not hsync");
endmodule : vigo_config_sva

bind vigo_config vigo_config_sva chk (.clk, .nrst, .reg_rd, .reg_rdata,
  .black_level_compensation, .coast, .clamp_time, .hsync_in, .clamp_pos_red,
  .clamp_pos_green, .clamp_pos_blue, .clamp_neg_tied, .analog_clamp,
  .clamp_level_red, .clamp_level_green, .shift_red, .shift_green, .shift_blue,
  .target_red, .target_green, .compensation_active, .sync_out, .composite_sync);

// *** sim/vigo_host.sv ***
// host controller model driving the register port
`timescale 1ns/10ps
module vigo_host
(
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // callers keep reserved bits clear except in refusal checks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : vigo_host

// *** sim/test_video_input_gain_offset_config.sv ***
// self-checking bench for the video configuration register bank
`timescale 1ns/10ps
`define CHK(g, e) cmp(10'(g), 10'(e))
module test_video_input_gain_offset_config;
  import vigo_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, hsync_in, green_sync_input, coast;
  logic black_level_compensation, clamp_time, second_input_set;
  logic clamp_pos_red, clamp_pos_green, clamp_pos_blue, clamp_neg_tied;
  logic analog_clamp, shift_red, shift_green, shift_blue;
  logic compensation_active, offset_range_quarter, sync_out, composite_sync;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, target_red, target_green;
  logic [7:0] target_blue, gain_red, gain_green, gain_blue, rv;
  logic signed [8:0] digital_offset_red, digital_offset_green;
  logic signed [8:0] digital_offset_blue;
  logic [9:0] offset_dac_red, offset_dac_green, offset_dac_blue;
  vigo_clamp_type clamp_level_red, clamp_level_green, clamp_level_blue;
  int err_total, checked;

  vigo_config dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .black_level_compensation, .coast, .clamp_time, .hsync_in,
    .green_sync_input, .second_input_set, .clamp_pos_red, .clamp_pos_green,
    .clamp_pos_blue, .clamp_neg_tied, .analog_clamp, .clamp_level_red,
    .clamp_level_green, .clamp_level_blue, .shift_red, .shift_green,
    .shift_blue, .target_red, .target_green, .target_blue,
    .compensation_active, .gain_red, .gain_green, .gain_blue,
    .digital_offset_red, .digital_offset_green, .digital_offset_blue,
    .offset_dac_red, .offset_dac_green, .offset_dac_blue,
    .offset_range_quarter, .sync_out, .composite_sync);
  vigo_host host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  task automatic cmp(input logic [9:0] g, input logic [9:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic t_reset;
    logic [7:0] ex [8] = '{8'h00, 8'h55, 8'h55, 8'h55,
                           8'h80, 8'h80, 8'h80, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      host.rd(ADDR_INPUT_CONFIG + 8'(i), rv);
      `CHK(rv, ex[i]);
    end
    host.rd(8'h0D, rv);
    `CHK(rv, 8'h00);
    `CHK(offset_dac_green, 10'h200);
    `CHK(digital_offset_blue, 9'sd0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
    begin
      host.wr(ADDR_INPUT_CONFIG + 8'(i), 8'hFF);
      host.rd(ADDR_INPUT_CONFIG + 8'(i), rv);
      `CHK(rv, i == 0 ? 8'h3F : i == 7 ? 8'hFD : 8'hFF);
    end
    host.wr(ADDR_RED_GAIN, 8'h00);
    settle();
    `CHK(gain_red, 8'h00);
    `CHK(gain_blue, 8'hFF);
    `CHK(gain_green, 8'hFF);
    host.wr(ADDR_INPUT_CONFIG, 8'h00);
    $display("test registers done");
  endtask : t_regs
  task automatic t_offset;
    host.wr(ADDR_OFFSET_DAC, 8'h9D);
    host.wr(ADDR_RED_OFFSET, 8'h00);
    host.wr(ADDR_GREEN_OFFSET, 8'h80);
    host.wr(ADDR_BLUE_OFFSET, 8'hFF);
    settle();
    `CHK(offset_dac_red, 10'h003);
    `CHK(offset_dac_green, 10'h201);
    `CHK(offset_dac_blue, 10'h3FE);
    `CHK(offset_range_quarter, 1'b1);
    @(posedge clk);
    black_level_compensation <= 1'b1;
    settle();
    `CHK(digital_offset_red, -9'sd128);
    `CHK(digital_offset_green, 9'sd0);
    `CHK(digital_offset_blue, 9'sd127);
    host.wr(ADDR_RED_OFFSET, 8'h40);
    settle();
    `CHK(digital_offset_red, -9'sd64);
    `CHK(offset_dac_red, 10'h003);
    @(posedge clk);
    black_level_compensation <= 1'b0;
    $display("test offset done");
  endtask : t_offset
  task automatic t_cfg;
    @(posedge clk);
    clamp_time <= 1'b1;
    hsync_in <= 1'b1;
    host.wr(ADDR_INPUT_CONFIG, 8'h00);
    settle();
    `CHK(clamp_pos_red, 1'b1);
    `CHK(clamp_neg_tied, 1'b1);
    host.wr(ADDR_INPUT_CONFIG, 8'h02);
    settle();
    `CHK(analog_clamp, 1'b0);
    `CHK(clamp_neg_tied, 1'b0);
    host.wr(ADDR_INPUT_CONFIG, 8'h04);
    settle();
    `CHK(clamp_level_blue, vigo_clamp_600mv_type_e);
    `CHK(target_blue, 8'h80);
    `CHK(shift_blue, 1'b0);
    host.wr(ADDR_INPUT_CONFIG, 8'h01);
    settle();
    `CHK(second_input_set, 1'b1);
    `CHK(clamp_level_blue, vigo_clamp_300mv_type_e);
    host.wr(ADDR_INPUT_CONFIG, 8'h08);
    settle();
    `CHK(sync_out, 1'b0);
    `CHK(composite_sync, 1'b1);
    @(posedge clk);
    green_sync_input <= 1'b1;
    hsync_in <= 1'b0;
    settle();
    `CHK(sync_out, 1'b1);
    host.wr(ADDR_INPUT_CONFIG, 8'h18);
    settle();
    `CHK(sync_out, 1'b0);
    host.wr(ADDR_INPUT_CONFIG, 8'h10);
    settle();
    `CHK(composite_sync, 1'b0);
    `CHK(sync_out, 1'b0);
    @(posedge clk);
    black_level_compensation <= 1'b1;
    coast <= 1'b1;
    host.wr(ADDR_INPUT_CONFIG, 8'h00);
    settle();
    `CHK(compensation_active, 1'b0);
    `CHK(clamp_pos_green, 1'b0);
    host.wr(ADDR_INPUT_CONFIG, 8'h20);
    settle();
    `CHK(compensation_active, 1'b1);
    `CHK(clamp_pos_blue, 1'b1);
    @(posedge clk);
    clamp_time <= 1'b0;
    settle();
    `CHK(clamp_pos_red, 1'b0);
    `CHK(clamp_neg_tied, 1'b1);
    $display("test config done");
  endtask : t_cfg
  task automatic t_midreset;
    @(posedge clk);
    coast <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    `CHK(compensation_active, 1'b1);
    `CHK(offset_range_quarter, 1'b0);
    `CHK(clamp_neg_tied, 1'b1);
    $display("test mid-run reset done");
  endtask : t_midreset

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial
  begin
    nrst = 1'b0;
    black_level_compensation = 1'b0;
    coast = 1'b0;
    clamp_time = 1'b0;
    hsync_in = 1'b0;
    green_sync_input = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_offset();
    t_cfg();
    t_midreset();
    end_of_test();
  end
endmodule : test_video_input_gain_offset_config
